// ==== design/nvrc_pkg.sv ====
`default_nettype none
package nvrc_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned TICK_HZ     = 1;
    localparam int unsigned POR_MIN_MS  = 40;
    localparam int unsigned WD_RES_US   = 62_500;
    localparam int unsigned TICK_CYC    = CLK_HZ / TICK_HZ;
    localparam int unsigned POR_CYC     = int'(64'(POR_MIN_MS) * CLK_HZ / 64'd1000);
    localparam int unsigned WD_BASE_CYC = int'(64'(WD_RES_US) * CLK_HZ / 64'd1000000);

    // ------------------------------------------------------------------
    // Map
    // ------------------------------------------------------------------
    localparam logic [18:0] STATUS_FLAGS_ADDR = 19'h7FFF0;
    localparam logic [14:0] RTC_PAGE          = STATUS_FLAGS_ADDR[18:4];
    localparam logic [3:0]  RI_FLAGS   = 4'h0;
    localparam logic [3:0]  RI_ALM_SEC = 4'h2;
    localparam logic [3:0]  RI_INTR    = 4'h6;
    localparam logic [3:0]  RI_WDOG    = 4'h7;
    localparam logic [3:0]  RI_CTRL    = 4'h8;
    localparam logic [3:0]  RI_SEC     = 4'h9;
    localparam int          B_W   = 7;
    localparam int          B_R   = 6;
    localparam int          B_OSC = 7;
    localparam int          B_AE  = 7;
    localparam int          B_ABE = 5;
    localparam int          B_AM  = 7;
    localparam int          B_WDS = 7;
    localparam int          B_WF  = 7;
    localparam int          B_AF  = 6;
    localparam int          B_BLF = 4;

    // ------------------------------------------------------------------
    // Time fields, index i sits at offset RI_CTRL + i
    // ------------------------------------------------------------------
    typedef logic [7:0]          nvrc_byte_t;
    typedef nvrc_byte_t [7:0]    nvrc_time_t;
    localparam nvrc_time_t CNT_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h07,
                                       8'h3F, 8'h7F, 8'h7F, 8'h3F};
    localparam nvrc_time_t TIME_RST = {8'h00, 8'h01, 8'h01, 8'h01,
                                       8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [3:0][2:0] ALM_FIELD = {3'd5, 3'd3, 3'd2, 3'd1};
    localparam nvrc_byte_t BCD_ZERO  = 8'h00;
    localparam nvrc_byte_t BCD_ONE   = 8'h01;
    localparam nvrc_byte_t SEC_TOP   = 8'h59;
    localparam nvrc_byte_t HOUR_TOP  = 8'h23;
    localparam nvrc_byte_t DAY_TOP   = 8'h07;
    localparam nvrc_byte_t MONTH_TOP = 8'h12;
    localparam nvrc_byte_t YEAR_TOP  = 8'h99;
    localparam nvrc_byte_t CENT_TOP  = 8'h39;
    localparam nvrc_byte_t FEB       = 8'h02;
    localparam nvrc_byte_t FEB_TOP   = 8'h28;
    localparam nvrc_byte_t LEAP_TOP  = 8'h29;
    localparam nvrc_byte_t SHORT_TOP = 8'h30;
    localparam nvrc_byte_t LONG_TOP  = 8'h31;
endpackage
`default_nettype wire

// ==== design/nvrc_time_if.sv ====
`default_nettype none
interface nvrc_time_if;
    import nvrc_pkg::*;
    logic       tick;
    logic       load;
    nvrc_time_t load_val;
    nvrc_time_t count;
    modport ctr (input tick, load, load_val, output count);
    modport ctl (output tick, load, load_val, input count);
endinterface
`default_nettype wire

// ==== design/nvrc_timekeep.sv ====
`default_nettype none
module nvrc_timekeep (
    input  wire logic clk,
    input  wire logic rst,
    nvrc_time_if.ctr  tif
);
    import nvrc_pkg::*;

    nvrc_time_t nxt;
    nvrc_byte_t mtop;
    nvrc_byte_t yr;
    logic       leap;
    logic       c_s, c_m, c_h, c_d, c_mo, c_y;

    function automatic nvrc_byte_t bcd_step(input nvrc_byte_t v, input nvrc_byte_t top,
                                           input nvrc_byte_t bot, input logic en);
        if (!en) return v;
        if (v >= top) return bot;
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // ------------------------------------------------------------------
    // Calendar carry chain
    // ------------------------------------------------------------------
    // Leap years are those divisible by four, which holds up to 2099 only.
    always_comb begin
        yr   = tif.count[7];
        leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
               (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
        unique case (tif.count[6])
            FEB:                          mtop = leap ? LEAP_TOP : FEB_TOP;
            8'h04, 8'h06, 8'h09, 8'h11:   mtop = SHORT_TOP;
            default:                      mtop = LONG_TOP;
        endcase
        c_s  = tif.count[1] >= SEC_TOP;
        c_m  = c_s && tif.count[2] >= SEC_TOP;
        c_h  = c_m && tif.count[3] >= HOUR_TOP;
        c_d  = c_h && tif.count[5] >= mtop;
        c_mo = c_d && tif.count[6] >= MONTH_TOP;
        c_y  = c_mo && tif.count[7] >= YEAR_TOP;
        nxt[1] = bcd_step(tif.count[1], SEC_TOP, BCD_ZERO, 1'b1);
        nxt[2] = bcd_step(tif.count[2], SEC_TOP, BCD_ZERO, c_s);
        nxt[3] = bcd_step(tif.count[3], HOUR_TOP, BCD_ZERO, c_m);
        nxt[4] = bcd_step(tif.count[4], DAY_TOP, BCD_ONE, c_h);
        nxt[5] = bcd_step(tif.count[5], mtop, BCD_ONE, c_h);
        nxt[6] = bcd_step(tif.count[6], MONTH_TOP, BCD_ONE, c_d);
        nxt[7] = bcd_step(tif.count[7], YEAR_TOP, BCD_ZERO, c_mo);
        nxt[0] = bcd_step(tif.count[0], CENT_TOP, BCD_ZERO, c_y);
    end

    // ------------------------------------------------------------------
    // Internal set
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            tif.count <= TIME_RST;
        end else if (tif.load) begin
            tif.count <= tif.load_val & CNT_MASK;
        end else if (tif.tick) begin
            tif.count <= nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_sec_range: assert property (tif.count[1] <= SEC_TOP)
        else $error("seconds left BCD range");
    chk_load_apply: assert property (tif.load |=>
        tif.count[1] == $past(tif.load_val[1] & CNT_MASK[1]))
        else $error("internal seconds not loaded");
    chk_hour_wrap: assert property (
        tif.tick && !tif.load && tif.count[3] == HOUR_TOP && c_m |=> tif.count[3] == BCD_ZERO)
        else $error("hour did not wrap to 00");
endmodule
`default_nettype wire

// ==== design/nvrc_ctrl.sv ====
`default_nettype none
// How it works
// - Top sixteen addresses go to clock registers.
// - Up to 524,272 RAM words; unused lines high.
// - Internal set counts; external set can freeze.
// - BCD 24-hour calendar with leap years.
// - Alarm match raises interrupt, optionally on battery.
// - Watchdog timeout raises interrupt or reset.
// - Below power-fail threshold all access blocked.
// - Read drives data only while output-enable low.
// - Write while chip-select and write-enable both low.
// - Write-enable low turns data outputs off.
// - Battery-low flag read-only, both batteries low.
// - Reset low on fail, held 40ms after.
// - Reset timing independent of the oscillator.
// - Accesses refused while reset output asserted.
// - Read-halt bit freezes external register updates.
// - Clearing write-halt loads internal counters.
module nvrc_ctrl #(
    parameter int unsigned TICK_CYCLES    = nvrc_pkg::TICK_CYC,
    parameter int unsigned POR_CYCLES     = nvrc_pkg::POR_CYC,
    parameter int unsigned WD_BASE_CYCLES = nvrc_pkg::WD_BASE_CYC
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RST,
    input  wire logic [18:0]         ADDRESS_PINS,
    input  wire logic                CE_N,
    input  wire logic                OE_N,
    input  wire logic                WE_N,
    input  wire nvrc_pkg::nvrc_byte_t DATA_PINS_I,
    output var  nvrc_pkg::nvrc_byte_t DATA_PINS_O,
    output logic                     DATA_PINS_OE,
    output logic                     RAM_CHIP_SELECT_N,
    output logic                     RAM_OUTPUT_DRIVE_N,
    input  wire logic                BELOW_POWER_FAIL_THRESHOLD,
    input  wire logic                BAT1_BELOW_MIN,
    input  wire logic                BAT2_BELOW_MIN,
    output logic                     ALARM_INTERRUPT_N_O,
    output logic                     ALARM_INTERRUPT_N_OE,
    output logic                     SYS_RESET_N_O,
    output logic                     SYS_RESET_N_OE
);
    import nvrc_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int PW = $clog2(POR_CYCLES + 1);
    localparam int WW = 40;

    nvrc_time_if tif ();

    nvrc_byte_t      regs_q [16];
    logic            blocked;
    logic            hit;
    logic            rd;
    logic            wr_hit;
    logic            commit;
    logic            wr_q;
    logic [3:0]      widx_q;
    nvrc_byte_t      wdat_q;
    logic            rdf;
    logic            rdf_q;
    logic            clr_flags;
    logic            af_q;
    logic            wf_q;
    logic [TW-1:0]   tick_cnt_q;
    logic            tick_q;
    logic            tick_d_q;
    logic [3:0]      am_ok;
    logic [PW-1:0]   por_cnt_q;
    logic [WW-1:0]   wd_cnt_q;
    logic [WW-1:0]   wd_limit;
    logic            wd_fire;
    logic            od_low_q;
    nvrc_byte_t      flags;
    nvrc_byte_t      wd_reg;
    logic            bat_low;

    // ------------------------------------------------------------------
    // Address decode and access gating
    // ------------------------------------------------------------------
    // The pins are sampled as synchronous, so the enables lag one cycle.
    always_comb begin
        hit     = ADDRESS_PINS[18:4] == RTC_PAGE;
        blocked = BELOW_POWER_FAIL_THRESHOLD || SYS_RESET_N_OE;
        rd      = !CE_N && WE_N && !blocked;
        wr_hit  = !CE_N && !WE_N && !blocked && hit;
        rdf     = rd && hit && ADDRESS_PINS[3:0] == RI_FLAGS;
        commit  = wr_q && !wr_hit && !blocked;
        clr_flags = rdf_q && !rdf;
        bat_low = BAT1_BELOW_MIN && BAT2_BELOW_MIN;
        flags   = '0;
        flags[B_WF]  = wf_q;
        flags[B_AF]  = af_q;
        flags[B_BLF] = bat_low;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            RAM_CHIP_SELECT_N  <= 1'b1;
            RAM_OUTPUT_DRIVE_N <= 1'b1;
        end else begin
            RAM_CHIP_SELECT_N  <= CE_N || hit || blocked;
            RAM_OUTPUT_DRIVE_N <= OE_N || hit || blocked;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            DATA_PINS_O  <= 8'h00;
            DATA_PINS_OE <= 1'b0;
            rdf_q        <= 1'b0;
        end else begin
            DATA_PINS_O  <= (ADDRESS_PINS[3:0] == RI_FLAGS) ? flags
                                                           : regs_q[ADDRESS_PINS[3:0]];
            DATA_PINS_OE <= hit && rd && !OE_N;
            rdf_q        <= rdf;
        end
    end

    // ------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------
    // Data is taken on the last cycle of the strobe, which is where a
    // static RAM latches it too; the address must not move meanwhile.
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wr_q   <= 1'b0;
            widx_q <= 4'h0;
            wdat_q <= 8'h00;
        end else begin
            wr_q <= wr_hit;
            if (wr_hit) begin
                widx_q <= ADDRESS_PINS[3:0];
                wdat_q <= DATA_PINS_I;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register file and external time set
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < 16; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else begin
            if (!(regs_q[RI_CTRL][B_W] || regs_q[RI_CTRL][B_R])) begin
                for (int i = 0; i < 8; i++) begin
                    regs_q[RI_CTRL + 4'(i)] <= (regs_q[RI_CTRL + 4'(i)] & ~CNT_MASK[i]) |
                                               (tif.count[i] & CNT_MASK[i]);
                end
            end
            if (commit && widx_q != RI_FLAGS) begin
                regs_q[widx_q] <= wdat_q;
            end
        end
    end

    // Loading happens in the commit cycle, while the halt still stands,
    // so the external copy cannot overwrite the new values first.
    always_comb begin
        tif.load = commit && widx_q == RI_CTRL && regs_q[RI_CTRL][B_W] &&
                   !wdat_q[B_W];
        for (int i = 0; i < 8; i++) begin
            tif.load_val[i] = regs_q[RI_CTRL + 4'(i)];
        end
        tif.load_val[0] = wdat_q;
        tif.tick        = tick_q;
    end

    nvrc_timekeep u_time (
        .clk (CORE_CLK),
        .rst (RST),
        .tif (tif.ctr)
    );

    // ------------------------------------------------------------------
    // One-second enable
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST || regs_q[RI_SEC][B_OSC]) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= tick_cnt_q == TW'(TICK_CYCLES - 1);
            if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            tick_d_q <= 1'b0;
        end else begin
            tick_d_q <= tick_q;
        end
    end

    // ------------------------------------------------------------------
    // Alarm
    // ------------------------------------------------------------------
    for (genvar a = 0; a < 4; a++) begin : g_alm
        assign am_ok[a] = regs_q[RI_ALM_SEC + 4'(a)][B_AM] ||
                          ((regs_q[RI_ALM_SEC + 4'(a)] ^ tif.count[ALM_FIELD[a]]) &
                           CNT_MASK[ALM_FIELD[a]]) == 8'h00;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            af_q <= 1'b0;
        end else if (tick_d_q && &am_ok) begin
            af_q <= 1'b1;
        end else if (clr_flags) begin
            af_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    always_comb begin
        wd_reg   = regs_q[RI_WDOG];
        wd_limit = WW'(wd_reg[6:2]) * (WW'(WD_BASE_CYCLES) << {wd_reg[1:0], 1'b0});
        wd_fire  = wd_limit != '0 && wd_cnt_q == wd_limit - 1'b1;
    end

    // Any write to the watchdog register counts as host activity.
    always_ff @(posedge CORE_CLK) begin
        if (RST || wd_limit == '0 || wd_fire || (commit && widx_q == RI_WDOG)) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wf_q <= 1'b0;
        end else if (wd_fire) begin
            wf_q <= 1'b1;
        end else if (clr_flags) begin
            wf_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and reset pins
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ALARM_INTERRUPT_N_OE <= 1'b0;
        end else begin
            ALARM_INTERRUPT_N_OE <= ((regs_q[RI_INTR][B_AE] && af_q) ||
                                     (wf_q && !regs_q[RI_WDOG][B_WDS])) &&
                                    (!BELOW_POWER_FAIL_THRESHOLD ||
                                     regs_q[RI_INTR][B_ABE]);
        end
    end

    // The hold counter runs on the core clock, never on the time tick.
    always_ff @(posedge CORE_CLK) begin
        if (RST || BELOW_POWER_FAIL_THRESHOLD ||
            (wd_fire && regs_q[RI_WDOG][B_WDS])) begin
            por_cnt_q <= PW'(POR_CYCLES);
        end else if (por_cnt_q != '0) begin
            por_cnt_q <= por_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            SYS_RESET_N_OE <= 1'b1;
            od_low_q       <= 1'b0;
        end else begin
            SYS_RESET_N_OE <= BELOW_POWER_FAIL_THRESHOLD || por_cnt_q != '0;
            od_low_q       <= 1'b0;
        end
    end

    assign ALARM_INTERRUPT_N_O = od_low_q;
    assign SYS_RESET_N_O       = od_low_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_supply_back;
        $fell(BELOW_POWER_FAIL_THRESHOLD);
    endsequence
    sequence s_reset_held;
        SYS_RESET_N_OE [*8];
    endsequence

    chk_rtc_hit_ram: assert property (hit && !CE_N |=> RAM_CHIP_SELECT_N)
        else $error("RAM selected on clock address");
    chk_fail_blocks: assert property (BELOW_POWER_FAIL_THRESHOLD |=>
        RAM_CHIP_SELECT_N && !DATA_PINS_OE ##1 SYS_RESET_N_OE)
        else $error("access passed under power fail");
    chk_read_drive: assert property (hit && rd && !OE_N |=> DATA_PINS_OE)
        else $error("read data not driven");
    chk_write_quiet: assert property (!WE_N |=> !DATA_PINS_OE)
        else $error("data driven during write");
    chk_deselect_off: assert property (CE_N |=> !DATA_PINS_OE && RAM_CHIP_SELECT_N)
        else $error("deselected but active");
    chk_ram_pass: assert property (!hit && !blocked |=>
        RAM_CHIP_SELECT_N == $past(CE_N) && RAM_OUTPUT_DRIVE_N == $past(OE_N))
        else $error("RAM enables not passed through");
    chk_blf_flag: assert property (rdf |=> DATA_PINS_O[B_BLF] == $past(bat_low))
        else $error("battery flag wrong");
    chk_por_hold: assert property (s_supply_back |=> s_reset_held)
        else $error("reset released too early");
    chk_reset_refuse: assert property (SYS_RESET_N_OE && !CE_N |=>
        RAM_CHIP_SELECT_N && !DATA_PINS_OE)
        else $error("access during reset");
    chk_halt_freeze: assert property (regs_q[RI_CTRL][B_R] && !commit |=>
        $stable(regs_q[RI_SEC]))
        else $error("external seconds moved while halted");
    chk_wr_load: assert property (tif.load |=>
        tif.count[1] == ($past(regs_q[RI_SEC]) & CNT_MASK[1]))
        else $error("write halt release did not load");
endmodule
`default_nettype wire

// ==== dv/nvrc_sram_model.sv ====
`default_nettype none
module nvrc_sram_model (
    input  wire logic        clk,
    input  wire logic [18:0] addr,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  din,
    output logic [7:0]       q,
    output logic             drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    // Only the low address byte is kept, so the model stays small.
    always @(posedge clk) begin
        if (!cs_n && !we_n) begin
            mem[addr[7:0]] <= din;
        end
    end
    // A released bus shows a fixed pattern rather than echoing the last byte.
    assign drive = !cs_n && !oe_n && we_n;
    assign q     = drive ? mem[addr[7:0]] : 8'h3C;
endmodule
`default_nettype wire

// ==== dv/nvrc_ctrl_tb_top.sv ====
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module nvrc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvrc_pkg::*;
    localparam int POR = 10;
    logic       clk, rst, ce_n, oe_n, we_n, below, bat1, bat2;
    logic       d_oe, ram_cs_n, ram_oe_n, ram_drive, irq_o, irq_oe, rst_o, rst_oe;
    logic [18:0] addr;
    nvrc_byte_t din, dout, bus, ram_q, v1, v2;
    int         mismatches, n_checks;
    // ----------------------------------------------------------------
    // Device and far side
    // ----------------------------------------------------------------
    nvrc_ctrl #(.TICK_CYCLES(20), .POR_CYCLES(POR), .WD_BASE_CYCLES(4)) dut (
        .CORE_CLK(clk), .RST(rst), .ADDRESS_PINS(addr), .CE_N(ce_n), .OE_N(oe_n),
        .WE_N(we_n), .DATA_PINS_I(din), .DATA_PINS_O(dout), .DATA_PINS_OE(d_oe),
        .RAM_CHIP_SELECT_N(ram_cs_n), .RAM_OUTPUT_DRIVE_N(ram_oe_n),
        .BELOW_POWER_FAIL_THRESHOLD(below), .BAT1_BELOW_MIN(bat1), .BAT2_BELOW_MIN(bat2),
        .ALARM_INTERRUPT_N_O(irq_o), .ALARM_INTERRUPT_N_OE(irq_oe),
        .SYS_RESET_N_O(rst_o), .SYS_RESET_N_OE(rst_oe));
    nvrc_sram_model ram (.clk(clk), .addr(addr), .cs_n(ram_cs_n), .oe_n(ram_oe_n),
        .we_n(we_n), .din(din), .q(ram_q), .drive(ram_drive));
    assign bus = d_oe ? dout : ram_q;
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task automatic acc(input logic [18:0] a, input logic ce, oe, we, output nvrc_byte_t v);
        @(negedge clk);
        addr = a;
        din = 8'h00;
        ce_n = ce;
        oe_n = oe;
        we_n = we;
        @(negedge clk);
        v = bus;
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
    endtask
    task automatic wr(input logic [18:0] a, input nvrc_byte_t d);
        @(negedge clk);
        addr = a;
        din = d;
        ce_n = 1'b0;
        we_n = 1'b0;
        repeat (2) @(negedge clk);
        ce_n = 1'b1;
        we_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_hold;
        repeat (POR - 4) @(negedge clk);
        `CHK("rst_oe", 1'b1, rst_oe)
        `CHK("rst_o", 1'b0, rst_o)
        acc(19'h7FFF9, 0, 0, 1, v1);
        `CHK("d_oe", 1'b0, d_oe)
        `CHK("ram_cs", 1'b1, ram_cs_n)
        repeat (6) @(negedge clk);
        `CHK("rst_oe", 1'b0, rst_oe)
    endtask
    task automatic t_map;
        // Upper lines tied high model a smaller RAM.
        wr(19'h7FF10, 8'hC3);
        acc(19'h7FF10, 0, 0, 1, v1);
        `CHK("ram_cs", 1'b0, ram_cs_n)
        `CHK("ram_oe", 1'b0, ram_oe_n)
        `CHK("ram_rd", 8'hC3, v1)
        `CHK("ram_drive", 1'b1, ram_drive)
        acc(19'h7FFF9, 0, 0, 1, v1);
        `CHK("ram_cs", 1'b1, ram_cs_n)
        `CHK("d_oe", 1'b1, d_oe)
        `CHK("ram_drive", 1'b0, ram_drive)
        acc(19'h7FFF9, 0, 1, 1, v1);
        `CHK("d_oe", 1'b0, d_oe)
        acc(19'h7FFF9, 1, 0, 1, v1);
        `CHK("d_oe", 1'b0, d_oe)
        acc(19'h7FFF1, 0, 0, 0, v1);
        `CHK("d_oe", 1'b0, d_oe)
    endtask
    task automatic t_bat;
        wr(19'h7FFF0, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            bat1 = i[0];
            bat2 = i[1];
            acc(19'h7FFF0, 0, 0, 1, v1);
            `CHK("flags", {3'b000, 1'(i == 3), 4'h0}, v1)
        end
    endtask
    task automatic t_clock;
        wr(19'h7FFF8, 8'h80);
        wr(19'h7FFF9, 8'h85);
        wr(19'h7FFF8, 8'h00);
        repeat (45) @(negedge clk);
        acc(19'h7FFF9, 0, 0, 1, v1);
        `CHK("sec_load", 8'h85, v1)
        wr(19'h7FFF8, 8'h80);
        wr(19'h7FFF9, 8'h59);
        wr(19'h7FFFA, 8'h00);
        wr(19'h7FFF8, 8'h00);
        repeat (30) @(negedge clk);
        acc(19'h7FFFA, 0, 0, 1, v1);
        `CHK("min_roll", 8'h01, v1)
        wr(19'h7FFF8, 8'h40);
        acc(19'h7FFF9, 0, 0, 1, v1);
        repeat (45) @(negedge clk);
        acc(19'h7FFF9, 0, 0, 1, v2);
        `CHK("sec_halt", v1, v2)
        wr(19'h7FFF8, 8'h00);
        acc(19'h7FFF9, 0, 0, 1, v2);
        `CHK("sec_runs", 1'b1, 1'(v2 != v1))
    endtask
    task automatic t_irq;
        {bat1, bat2} = 2'b00;
        wr(19'h7FFF7, 8'h04);
        repeat (6) @(negedge clk);
        `CHK("irq_oe", 1'b1, irq_oe)
        `CHK("irq_o", 1'b0, irq_o)
        acc(19'h7FFF0, 0, 0, 1, v1);
        `CHK("wf", 1'b1, v1[B_WF])
        wr(19'h7FFF7, 8'h00);
        acc(19'h7FFF0, 0, 0, 1, v1);
        acc(19'h7FFF0, 0, 0, 1, v1);
        `CHK("flags", 8'h00, v1)
        `CHK("irq_oe", 1'b0, irq_oe)
        for (int i = 2; i < 7; i++) begin
            wr(19'h7FFF0 + 19'(i), 8'h80);
        end
        repeat (26) @(negedge clk);
        `CHK("irq_oe", 1'b1, irq_oe)
        acc(19'h7FFF0, 0, 0, 1, v1);
        `CHK("af", 1'b1, v1[B_AF])
        repeat (26) @(negedge clk);
        `CHK("irq_oe", 1'b1, irq_oe)
    endtask
    task automatic t_pf;
        @(negedge clk);
        below = 1'b1;
        acc(19'h7FF10, 0, 0, 1, v1);
        `CHK("ram_cs", 1'b1, ram_cs_n)
        acc(19'h7FFF9, 0, 0, 1, v1);
        `CHK("d_oe", 1'b0, d_oe)
        `CHK("rst_oe", 1'b1, rst_oe)
        `CHK("irq_oe", 1'b0, irq_oe)
        below = 1'b0;
        repeat (POR - 2) @(negedge clk);
        `CHK("rst_oe", 1'b1, rst_oe)
        repeat (6) @(negedge clk);
        `CHK("rst_oe", 1'b0, rst_oe)
        `CHK("irq_oe", 1'b1, irq_oe)
    endtask
    // ----------------------------------------------------------------
    // Run
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(4000 * 8);
        mismatches++;
        finish_test();
    end
    initial begin
        {rst, ce_n, oe_n, we_n} = 4'hF;
        {below, bat1, bat2, addr, din} = '0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_hold();
        t_map();
        t_bat();
        t_clock();
        t_irq();
        t_pf();
        finish_test();
    end
endmodule
`undef CHK
`default_nettype wire
